// file: verilog/supply_reset_pkg.sv
// Summary of operation
// - Supply below trip level holds reset, drives pin.
// - Power-on sets monitor enable; other resets keep it.
// - Unprotected flash write or erase forces error reset.
// - Bit 7 enables monitor; resets need source select.
// - Bit 6 reads live supply-above-threshold status.
// - Bit 5 selects high or low threshold, resets 0.
// - Bits 4 to 0 read zero, ignore writes.
// - No power-on delay after a monitor reset.
// - Power-on forces low threshold; others keep level.
// - Low reset pin holds the device in reset.
// - Pin reset sets pin flag, bit 0, on exit.
// - Power or monitor reset sets power flag, bit 1.
// - Flash error reset sets flash flag, bit 6.
package supply_reset_pkg;

    // Clock and timing.
    localparam int unsigned CLK_FREQ_MHZ = 250;
    localparam int unsigned POR_DELAY_US = 100;
    localparam int unsigned POR_DELAY_CYCLES = POR_DELAY_US * CLK_FREQ_MHZ;
    localparam int unsigned FLASH_ERR_PULSE_NS = 100;
    localparam int unsigned FLASH_ERR_CYCLES = (FLASH_ERR_PULSE_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int unsigned SYNC_STAGES = 2;

    // Register bus geometry.
    localparam int unsigned AXI_ADDR_W = 12;
    localparam int unsigned AXI_DATA_W = 32;
    localparam logic [7:0] CTRL_IDX = 8'hff;
    localparam logic [7:0] CAUSE_IDX = 8'hef;
    localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] CAUSE_ADDR = {2'h0, CAUSE_IDX, 2'h0};
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Field positions.
    localparam int unsigned MON_EN_BIT = 7;
    localparam int unsigned SUPPLY_STAT_BIT = 6;
    localparam int unsigned LEVEL_BIT = 5;
    localparam int unsigned PIN_FLAG_BIT = 0;
    localparam int unsigned POWER_FLAG_BIT = 1;
    localparam int unsigned FLASH_FLAG_BIT = 6;

    // Values after power-on.
    localparam logic MON_EN_POR = 1'h1;
    localparam logic LEVEL_POR = 1'h0;
    localparam logic SRC_EN_POR = 1'h1;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_HOLD = 2'h1,
        ST_DELAY = 2'h3,
        ST_PULSE = 2'h2
    } state_t;

    typedef enum logic [1:0] {
        CAUSE_NONE = 2'h0,
        CAUSE_POWER = 2'h1,
        CAUSE_PIN = 2'h2,
        CAUSE_FLASH = 2'h3
    } cause_t;

endpackage

// file: verilog/sync_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sync_if #(
    parameter int unsigned WIDTH = 2
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface // sync_if
`default_nettype wire

// file: verilog/sync_stages.sv
`timescale 1ns/100ps
`default_nettype none
module sync_stages #(
    parameter int unsigned WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '1
)(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Raw and synchronised levels.
    sync_if.dst port
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            logic stable_reg;
            // The first stage feeds only the second.
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    meta_reg <= RST_VAL[i];
                    stable_reg <= RST_VAL[i];
                end else begin
                    meta_reg <= port.raw[i];
                    stable_reg <= meta_reg;
                end
            end
            assign port.synced[i] = stable_reg;
        end
    endgenerate
endmodule // sync_stages
`default_nettype wire

// file: verilog/supply_reset_ctrl.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module supply_reset_ctrl #(
    parameter int unsigned POR_DELAY_CYC = supply_reset_pkg::POR_DELAY_CYCLES
)(
    // Clock and power-on reset.
    input wire logic mclk_in,
    input wire logic rst_in,
    // AXI4-Lite write channels.
    input wire logic [supply_reset_pkg::AXI_ADDR_W-1:0] axi_awaddr_in,
    input wire logic axi_awvalid_in,
    output logic axi_awready_out,
    input wire logic [supply_reset_pkg::AXI_DATA_W-1:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    input wire logic axi_wvalid_in,
    output logic axi_wready_out,
    output logic [1:0] axi_bresp_out,
    output logic axi_bvalid_out,
    input wire logic axi_bready_in,
    // AXI4-Lite read channels.
    input wire logic [supply_reset_pkg::AXI_ADDR_W-1:0] axi_araddr_in,
    input wire logic axi_arvalid_in,
    output logic axi_arready_out,
    output logic [supply_reset_pkg::AXI_DATA_W-1:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    output logic axi_rvalid_out,
    input wire logic axi_rready_in,
    // Analog supply monitor.
    input wire logic supply_above_raw_in,
    output logic monitor_enable_out,
    output logic threshold_level_select_out,
    // Reset pin, active low, open drain.
    input wire logic rst_pin_n_in,
    output logic rst_pin_n_out,
    output logic rst_pin_oe_out,
    // Flash programming guard.
    input wire logic flash_prog_req_in,
    output logic flash_prog_ok_out,
    // Core reset.
    output logic core_reset_out
);
    import supply_reset_pkg::*;

    localparam int unsigned CNT_W = $clog2(POR_DELAY_CYC + FLASH_ERR_CYCLES + 1);
    localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_DELAY_CYC - 1);
    localparam logic [CNT_W-1:0] FLASH_LOAD = CNT_W'(FLASH_ERR_CYCLES - 1);

    logic supply_sync;
    logic pin_sync;
    logic mon_en_reg;
    logic level_reg;
    logic src_en_reg;
    logic pin_flag_reg;
    logic power_flag_reg;
    logic flash_flag_reg;
    state_t state_reg;
    state_t state_next;
    cause_t cause_reg;
    cause_t cause_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [SYNC_STAGES:0] drive_hist_reg;
    logic pin_oe_reg;
    logic pin_level_reg;
    logic core_reset_reg;
    logic flash_ok_reg;
    logic trip;
    logic pin_ext;
    logic flash_allowed;
    logic flash_err;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic [AXI_ADDR_W-1:0] awaddr_reg;
    logic [AXI_DATA_W-1:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [AXI_DATA_W-1:0] rdata_reg;
    logic wr_fire;
    logic ar_take;
    logic wr_ctrl;
    logic wr_cause;

    // Comparator and pin are asynchronous; both pass a two-stage synchroniser.
    sync_if #(.WIDTH(2)) sif ();
    assign sif.raw = {rst_pin_n_in, supply_above_raw_in};
    sync_stages #(.WIDTH(2), .RST_VAL(2'h3)) u_sync (
        .clk_in(mclk_in),
        .rst_in(rst_in),
        .port(sif.dst)
    );
    assign supply_sync = sif.synced[0];
    assign pin_sync = sif.synced[1];

    // Monitor resets only when both enabled and selected as a source.
    assign trip = mon_en_reg && src_en_reg && !supply_sync;
    // Our own drive and its echo through the synchroniser must not look external.
    assign pin_ext = !pin_sync && !pin_oe_reg && (drive_hist_reg == '0);
    assign flash_allowed = mon_en_reg && level_reg && src_en_reg;
    assign flash_err = flash_prog_req_in && !flash_allowed && (state_reg == ST_RUN);

    always_comb begin
        state_next = state_reg;
        cause_next = cause_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_RUN: begin
                if (trip) begin
                    state_next = ST_HOLD;
                    cause_next = CAUSE_POWER;
                end else if (pin_ext) begin
                    state_next = ST_HOLD;
                    cause_next = CAUSE_PIN;
                end else if (flash_err) begin
                    state_next = ST_PULSE;
                    cause_next = CAUSE_FLASH;
                    cnt_next = FLASH_LOAD;
                end
            end
            ST_PULSE: begin
                if (trip) begin
                    state_next = ST_HOLD;
                    cause_next = CAUSE_POWER;
                end else if (pin_ext) begin
                    state_next = ST_HOLD;
                    cause_next = CAUSE_PIN;
                end else if (cnt_reg == '0) begin
                    state_next = ST_RUN;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            ST_HOLD: begin
                // Release goes straight to run, without the power-on delay.
                if (trip) begin
                    cause_next = CAUSE_POWER;
                end else if (!pin_ext) begin
                    state_next = ST_RUN;
                end
            end
            ST_DELAY: begin
                if (trip) begin
                    state_next = ST_HOLD;
                    cause_next = CAUSE_POWER;
                end else if (pin_ext) begin
                    state_next = ST_HOLD;
                    cause_next = CAUSE_PIN;
                end else if (cnt_reg == '0) begin
                    state_next = ST_RUN;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_reg <= ST_DELAY;
            cause_reg <= CAUSE_POWER;
            cnt_reg <= POR_LOAD;
        end else begin
            state_reg <= state_next;
            cause_reg <= cause_next;
            cnt_reg <= cnt_next;
        end
    end

    // Core reset and pin drive; the pin is pulled low only for power causes.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            core_reset_reg <= 1'h1;
            pin_oe_reg <= 1'h1;
            pin_level_reg <= 1'h0;
            drive_hist_reg <= '1;
        end else begin
            core_reset_reg <= (state_next != ST_RUN);
            pin_oe_reg <= (state_next != ST_RUN) && (cause_next == CAUSE_POWER);
            pin_level_reg <= 1'h0;
            drive_hist_reg <= {drive_hist_reg[SYNC_STAGES-1:0], pin_oe_reg};
        end
    end

    // Cause flags are written once, on leaving reset; no software clear exists.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pin_flag_reg <= 1'h0;
            power_flag_reg <= 1'h0;
            flash_flag_reg <= 1'h0;
        end else if (state_reg != ST_RUN && state_next == ST_RUN) begin
            pin_flag_reg <= (cause_reg == CAUSE_PIN);
            power_flag_reg <= (cause_reg == CAUSE_POWER);
            flash_flag_reg <= (cause_reg == CAUSE_FLASH);
        end
    end

    // Monitor control survives every reset but power-on.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            mon_en_reg <= MON_EN_POR;
            level_reg <= LEVEL_POR;
        end else if (wr_ctrl && wstrb_reg[0]) begin
            mon_en_reg <= wdata_reg[MON_EN_BIT];
            level_reg <= wdata_reg[LEVEL_BIT];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            src_en_reg <= SRC_EN_POR;
        end else if (wr_cause && wstrb_reg[0]) begin
            src_en_reg <= wdata_reg[POWER_FLAG_BIT];
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            flash_ok_reg <= 1'h0;
        end else begin
            flash_ok_reg <= flash_prog_req_in && flash_allowed && (state_reg == ST_RUN);
        end
    end

    // Register bus: write address and data are held until the response is taken.
    assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
    assign wr_ctrl = wr_fire && (awaddr_reg == CTRL_ADDR);
    assign wr_cause = wr_fire && (awaddr_reg == CAUSE_ADDR);
    assign ar_take = axi_arvalid_in && arready_reg;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            awready_reg <= 1'h1;
            wready_reg <= 1'h1;
            bvalid_reg <= 1'h0;
            bresp_reg <= RESP_OKAY;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= 4'h0;
        end else begin
            if (axi_awvalid_in && awready_reg) begin
                awready_reg <= 1'h0;
                awaddr_reg <= axi_awaddr_in;
            end
            if (axi_wvalid_in && wready_reg) begin
                wready_reg <= 1'h0;
                wdata_reg <= axi_wdata_in;
                wstrb_reg <= axi_wstrb_in;
            end
            if (wr_fire) begin
                bvalid_reg <= 1'h1;
                bresp_reg <= (wr_ctrl || wr_cause) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_reg && axi_bready_in) begin
                bvalid_reg <= 1'h0;
                awready_reg <= 1'h1;
                wready_reg <= 1'h1;
            end
        end
    end

    // Reserved bits read zero; writes to them land nowhere.
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            arready_reg <= 1'h1;
            rvalid_reg <= 1'h0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
        end else if (ar_take) begin
            arready_reg <= 1'h0;
            rvalid_reg <= 1'h1;
            if (axi_araddr_in == CTRL_ADDR) begin
                rdata_reg <= {24'h0, mon_en_reg, supply_sync, level_reg, 5'h00};
                rresp_reg <= RESP_OKAY;
            end else if (axi_araddr_in == CAUSE_ADDR) begin
                rdata_reg <= {24'h0, 1'h0, flash_flag_reg, 4'h0, power_flag_reg, pin_flag_reg};
                rresp_reg <= RESP_OKAY;
            end else begin
                rdata_reg <= '0;
                rresp_reg <= RESP_SLVERR;
            end
        end else if (rvalid_reg && axi_rready_in) begin
            rvalid_reg <= 1'h0;
            arready_reg <= 1'h1;
        end
    end

    assign axi_awready_out = awready_reg;
    assign axi_wready_out = wready_reg;
    assign axi_bvalid_out = bvalid_reg;
    assign axi_bresp_out = bresp_reg;
    assign axi_arready_out = arready_reg;
    assign axi_rvalid_out = rvalid_reg;
    assign axi_rresp_out = rresp_reg;
    assign axi_rdata_out = rdata_reg;
    assign monitor_enable_out = mon_en_reg;
    assign threshold_level_select_out = level_reg;
    assign rst_pin_n_out = pin_level_reg;
    assign rst_pin_oe_out = pin_oe_reg;
    assign flash_prog_ok_out = flash_ok_reg;
    // Core reset is registered, so it trails the sources by one clock.
    assign core_reset_out = core_reset_reg;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    trip_holds_core_a: assert property (trip |=> core_reset_out && state_reg == ST_HOLD)
        else $error("supply trip did not hold the core in reset");

    trip_drives_pin_a: assert property (trip |=> rst_pin_oe_out && !rst_pin_n_out)
        else $error("supply trip did not drive the reset pin low");

    por_defaults_a: assert property ($past(rst_in) |-> mon_en_reg && !level_reg && src_en_reg)
        else $error("power-on did not restore monitor defaults");

    enable_kept_a: assert property (core_reset_out && !wr_ctrl |=> $stable(mon_en_reg) && $stable(level_reg))
        else $error("monitor control changed by a core reset");

    flash_guard_a: assert property (flash_prog_req_in && state_reg == ST_RUN && !flash_allowed
        |=> state_reg == ST_PULSE && !flash_prog_ok_out ##1 core_reset_out)
        else $error("unprotected flash access did not reset");

    status_read_a: assert property (ar_take && axi_araddr_in == CTRL_ADDR
        |=> axi_rvalid_out && axi_rdata_out[SUPPLY_STAT_BIT] == $past(supply_sync)
        && axi_rdata_out[4:0] == 5'h00)
        else $error("control read showed wrong status or reserved bits");

    no_por_delay_a: assert property (state_reg == ST_HOLD && !trip && !pin_ext
        |=> state_reg == ST_RUN && !core_reset_out)
        else $error("power-on delay applied after a held reset");

    pin_flag_a: assert property (state_reg == ST_HOLD && state_next == ST_RUN && cause_reg == CAUSE_PIN
        |=> pin_flag_reg && !power_flag_reg && !flash_flag_reg)
        else $error("pin reset flag not set on exit");

    power_flag_a: assert property (state_reg != ST_RUN && state_next == ST_RUN && cause_reg == CAUSE_POWER
        |=> power_flag_reg && !pin_flag_reg)
        else $error("power reset flag not set on exit");

    flash_flag_a: assert property (state_reg == ST_PULSE && state_next == ST_RUN
        |=> flash_flag_reg && !core_reset_out)
        else $error("flash error flag not set on exit");

endmodule // supply_reset_ctrl
`default_nettype wire

// file: verif/supply_partner.sv
`timescale 1ns/100ps
`default_nettype none
module supply_partner (
    // Clock.
    input wire logic mclk_in,
    // Device side.
    input wire logic monitor_enable_in,
    input wire logic level_in,
    input wire logic pin_drv_n_in,
    input wire logic pin_oe_in,
    output logic supply_above_out,
    output logic pin_level_out,
    // Bench controls.
    input wire logic above_low_in,
    input wire logic above_high_in,
    input wire logic ext_low_in
);
    logic junk_reg = 1'h0;
    // A switched-off comparator gives no trustworthy answer, so it chatters.
    always_ff @(posedge mclk_in) begin
        junk_reg <= ~junk_reg;
    end
    assign supply_above_out = !monitor_enable_in ? junk_reg : (level_in ? above_high_in : above_low_in);
    // The pin has a pull-up, and either party may pull it low.
    assign pin_level_out = !((pin_oe_in && !pin_drv_n_in) || ext_low_in);
endmodule // supply_partner
`default_nettype wire

// file: verif/supply_monitor_and_pin_reset_tb.sv
`timescale 1ns/100ps
`default_nettype none
module supply_monitor_and_pin_reset_tb;
    import supply_reset_pkg::*;
    localparam int POR_DLY = 20;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [1:0] br;
        logic [31:0] rd;
        logic [1:0] rr;
    } row_t;
    row_t rows [4] = '{
        '{CTRL_ADDR, 32'h9f, RESP_OKAY, 32'hc0, RESP_OKAY},
        '{CTRL_ADDR, 32'hff, RESP_OKAY, 32'he0, RESP_OKAY},
        '{12'h010, 32'hff, RESP_SLVERR, 32'h0, RESP_SLVERR},
        '{CTRL_ADDR, 32'h80, RESP_OKAY, 32'hc0, RESP_OKAY}
    };
    logic mclk_in = 1'h0;
    logic rst_in = 1'h1;
    logic [11:0] axi_awaddr = 12'h0;
    logic axi_awvalid = 1'h0;
    logic [31:0] axi_wdata = 32'h0;
    logic axi_wvalid = 1'h0;
    logic axi_bready = 1'h0;
    logic [11:0] axi_araddr = 12'h0;
    logic axi_arvalid = 1'h0;
    logic axi_rready = 1'h0;
    logic flash_req = 1'h0;
    logic above_low = 1'h1;
    logic above_high = 1'h1;
    logic ext_low = 1'h0;
    logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out;
    logic [1:0] axi_bresp_out, axi_rresp_out;
    logic [31:0] axi_rdata_out;
    logic supply_above, monitor_enable_out, threshold_level_select_out, pin_level;
    logic rst_pin_n_out, rst_pin_oe_out, flash_prog_ok_out, core_reset_out;
    int failures = 0;
    int compares = 0;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    logic seen;

    always #2 mclk_in = ~mclk_in;

    supply_reset_ctrl #(.POR_DELAY_CYC(POR_DLY)) uut (
        .mclk_in(mclk_in), .rst_in(rst_in),
        .axi_awaddr_in(axi_awaddr), .axi_awvalid_in(axi_awvalid), .axi_awready_out(axi_awready_out),
        .axi_wdata_in(axi_wdata), .axi_wstrb_in(4'hf), .axi_wvalid_in(axi_wvalid),
        .axi_wready_out(axi_wready_out), .axi_bresp_out(axi_bresp_out), .axi_bvalid_out(axi_bvalid_out),
        .axi_bready_in(axi_bready), .axi_araddr_in(axi_araddr), .axi_arvalid_in(axi_arvalid),
        .axi_arready_out(axi_arready_out), .axi_rdata_out(axi_rdata_out), .axi_rresp_out(axi_rresp_out),
        .axi_rvalid_out(axi_rvalid_out), .axi_rready_in(axi_rready),
        .supply_above_raw_in(supply_above), .monitor_enable_out(monitor_enable_out),
        .threshold_level_select_out(threshold_level_select_out), .rst_pin_n_in(pin_level),
        .rst_pin_n_out(rst_pin_n_out), .rst_pin_oe_out(rst_pin_oe_out), .flash_prog_req_in(flash_req),
        .flash_prog_ok_out(flash_prog_ok_out), .core_reset_out(core_reset_out)
    );

    supply_partner partner (
        .mclk_in(mclk_in), .monitor_enable_in(monitor_enable_out), .level_in(threshold_level_select_out),
        .pin_drv_n_in(rst_pin_n_out), .pin_oe_in(rst_pin_oe_out), .supply_above_out(supply_above),
        .pin_level_out(pin_level), .above_low_in(above_low), .above_high_in(above_high), .ext_low_in(ext_low)
    );

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rsp);
        int k;
        logic aw_left;
        logic w_left;
        @(posedge mclk_in);
        k = 0;
        aw_left = 1'h1;
        w_left = 1'h1;
        axi_awaddr <= a;
        axi_awvalid <= 1'h1;
        axi_wdata <= v;
        axi_wvalid <= 1'h1;
        axi_bready <= 1'h1;
        while ((aw_left || w_left) && k < 100) begin
            @(posedge mclk_in);
            k++;
            if (aw_left && axi_awready_out === 1'h1) begin
                aw_left = 1'h0;
                axi_awvalid <= 1'h0;
            end
            if (w_left && axi_wready_out === 1'h1) begin
                w_left = 1'h0;
                axi_wvalid <= 1'h0;
            end
        end
        while (axi_bvalid_out !== 1'h1 && k < 200) begin
            @(posedge mclk_in);
            k++;
        end
        rsp = axi_bresp_out;
        axi_bready <= 1'h0;
        chk("write_done", 32'h1, {31'h0, k < 200});
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
        int k;
        @(posedge mclk_in);
        k = 0;
        axi_araddr <= a;
        axi_arvalid <= 1'h1;
        axi_rready <= 1'h1;
        do begin
            @(posedge mclk_in);
            k++;
        end while (axi_arready_out !== 1'h1 && k < 100);
        axi_arvalid <= 1'h0;
        while (axi_rvalid_out !== 1'h1 && k < 200) begin
            @(posedge mclk_in);
            k++;
        end
        v = axi_rdata_out;
        rsp = axi_rresp_out;
        axi_rready <= 1'h0;
        chk("read_done", 32'h1, {31'h0, k < 200});
    endtask

    task automatic wait_core(input logic v, input int lim, output int k);
        k = 0;
        while (core_reset_out !== v && k < lim) begin
            @(posedge mclk_in);
            k++;
        end
    endtask

    task automatic flash_pulse();
        @(posedge mclk_in);
        flash_req <= 1'h1;
        @(posedge mclk_in);
        flash_req <= 1'h0;
    endtask

    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #40000;
        failures++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'h0;
        wait_core(1'h0, 200, n);
        chk("por_delay", 32'h1, {31'h0, n >= POR_DLY && n <= POR_DLY + 3});
        axi_read(CAUSE_ADDR, d, r);
        chk("cause_por", 32'h2, d);
        axi_read(CTRL_ADDR, d, r);
        chk("ctrl_por", 32'hc0, d);
        foreach (rows[i]) begin
            axi_write(rows[i].a, rows[i].d, r);
            chk("bresp", {30'h0, rows[i].br}, {30'h0, r});
            axi_read(rows[i].a, d, r);
            chk("rdata", rows[i].rd, d);
            chk("rresp", {30'h0, rows[i].rr}, {30'h0, r});
        end
        // Supply dip with monitor enabled and selected.
        above_low <= 1'h0;
        wait_core(1'h1, 10, n);
        chk("trip_core", 32'h1, {31'h0, core_reset_out});
        chk("trip_pin", 32'h1, {31'h0, rst_pin_oe_out});
        chk("trip_pin_n", 32'h0, {31'h0, rst_pin_n_out});
        repeat (30) @(posedge mclk_in);
        chk("trip_hold", 32'h1, {31'h0, core_reset_out});
        above_low <= 1'h1;
        wait_core(1'h0, 100, n);
        chk("trip_release", 32'h1, {31'h0, n < POR_DLY});
        axi_read(CAUSE_ADDR, d, r);
        chk("cause_mon", 32'h2, d);
        // Source deselected: status still visible, no reset.
        axi_write(CAUSE_ADDR, 32'h0, r);
        above_low <= 1'h0;
        repeat (10) @(posedge mclk_in);
        chk("no_src_core", 32'h0, {31'h0, core_reset_out});
        axi_read(CTRL_ADDR, d, r);
        chk("stat_low", 32'h80, d);
        above_low <= 1'h1;
        repeat (5) @(posedge mclk_in);
        axi_read(CTRL_ADDR, d, r);
        chk("stat_high", 32'hc0, d);
        // Monitor switched off but selected: no reset.
        axi_write(CTRL_ADDR, 32'h0, r);
        axi_write(CAUSE_ADDR, 32'h2, r);
        above_low <= 1'h0;
        repeat (10) @(posedge mclk_in);
        chk("off_core", 32'h0, {31'h0, core_reset_out});
        above_low <= 1'h1;
        // External pin reset keeps the disabled monitor disabled.
        ext_low <= 1'h1;
        wait_core(1'h1, 10, n);
        chk("pin_core", 32'h1, {31'h0, core_reset_out});
        repeat (5) @(posedge mclk_in);
        ext_low <= 1'h0;
        wait_core(1'h0, 50, n);
        axi_read(CAUSE_ADDR, d, r);
        chk("cause_pin", 32'h1, d);
        axi_read(CTRL_ADDR, d, r);
        chk("ctrl_kept", 32'h0, d & 32'hbf);
        // The source is still selected from above; deselect it so the enable cannot meet a settling comparator.
        axi_write(CAUSE_ADDR, 32'h0, r);
        // Enable first, then select as source, with no wait between.
        axi_write(CTRL_ADDR, 32'h80, r);
        axi_write(CAUSE_ADDR, 32'h2, r);
        chk("enable_no_rst", 32'h0, {31'h0, core_reset_out});
        // Flash write at the low level is refused with a reset.
        flash_pulse();
        wait_core(1'h1, 5, n);
        wait_core(1'h0, 100, n);
        chk("flash_err_len", 32'h1, {31'h0, n >= FLASH_ERR_CYCLES - 2 && n <= FLASH_ERR_CYCLES + 2});
        axi_read(CAUSE_ADDR, d, r);
        chk("cause_flash", 32'h40, d);
        // High level only around the flash write.
        axi_write(CTRL_ADDR, 32'ha0, r);
        flash_pulse();
        seen = 1'h0;
        repeat (3) begin
            @(posedge mclk_in);
            seen = seen | flash_prog_ok_out;
        end
        chk("flash_ok", 32'h1, {31'h0, seen});
        chk("flash_no_rst", 32'h0, {31'h0, core_reset_out});
        axi_write(CTRL_ADDR, 32'h80, r);
        // High level above the regulator: stuck until power-on reset.
        axi_write(CTRL_ADDR, 32'ha0, r);
        above_high <= 1'h0;
        wait_core(1'h1, 10, n);
        repeat (100) @(posedge mclk_in);
        chk("stuck_core", 32'h1, {31'h0, core_reset_out});
        rst_in <= 1'h1;
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'h0;
        wait_core(1'h0, 200, n);
        chk("por_exit", 32'h0, {31'h0, core_reset_out});
        chk("por_level", 32'h0, {31'h0, threshold_level_select_out});
        chk("por_enable", 32'h1, {31'h0, monitor_enable_out});
        wrap_up();
    end
endmodule // supply_monitor_and_pin_reset_tb
`default_nettype wire
